// file: rtl/msch_pkg.sv
// Constants, field layouts and carriers shared by the serial command handler.
package msch_pkg;
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam longint unsigned SCAN_WAIT_S = 10;
    localparam longint unsigned SCAN_WAIT_CYC = SCAN_WAIT_S * CLK_HZ;
    localparam longint unsigned TAG_UNIT_MS = 100;
    localparam longint unsigned TAG_UNIT_CYC = TAG_UNIT_MS * CLK_HZ / 1000;

    localparam logic [7:0] CMD_PIN_WR = 8'h00AD;
    localparam logic [7:0] CMD_SCAN = 8'h00BC;
    localparam logic [7:0] CMD_TYPE = 8'h00C3;
    localparam logic [7:0] CMD_SLEEP = 8'h00B1;
    localparam logic [7:0] CMD_WAKE = 8'h00B2;
    localparam logic [7:0] CODE_ERR = 8'h00FF;
    localparam logic [7:0] CONFIRM = 8'h0000;
    localparam logic [7:0] WAKE_BY_SERIAL = 8'h0000;
    localparam logic [7:0] REQ_HDR = 8'h0080;
    localparam logic [7:0] RSP_HDR = 8'h00C0;
    localparam logic [7:0] HDR_MASK = 8'h00F0;
    localparam logic [7:0] LQI_BYTE = 8'h0000;
    localparam logic [7:0] PIN_FIRST = 8'h0003;
    localparam logic [7:0] PIN_LAST = 8'h000A;
    localparam logic [7:0] LVL_HIGH = 8'h0001;

    // Byte positions inside a frame, then frame, table and sample sizes.
    localparam int IDX_HDR = 0;
    localparam int IDX_LQI = 1;
    localparam int IDX_NODE_HI = 2;
    localparam int IDX_NODE_LO = 3;
    localparam int IDX_LEN = 4;
    localparam int IDX_CMD = 5;
    localparam int IDX_PL = 6;
    localparam int FRAME_OVH = 6;
    localparam int RX_MAX = 32;
    localparam int RSP_MAX = 32;
    localparam int NBR_MAX = 10;
    localparam int NBR_BYTES = 3;
    localparam int ADC_BITS = 10;

    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ODD = 2'h1;
    localparam logic [1:0] PAR_EVEN = 2'h2;

    localparam logic [7:0] REG_CFG = 8'h0000;
    localparam logic [7:0] REG_NODE = 8'h0004;
    localparam logic [7:0] REG_STAT = 8'h0008;
    localparam logic [15:0] NODE_RST = 16'h0000;

    typedef struct packed {
        logic transparent_loopback_enable;
        logic serial_flow_control_select;
        logic [1:0] serial_parity_select;
        logic tag_idle_sleep_enable;
        logic [7:0] tag_report_period;
    } msch_cfg_s;

    typedef struct packed {
        logic scan_busy;
        logic tag_busy;
        logic sleeping;
        logic [7:0] port_level;
    } msch_stat_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] rssi;
    } msch_nbr_s;

    typedef struct packed {
        logic [15:0] ch0;
        logic [15:0] ch1;
    } msch_adc_s;
endpackage

// file: rtl/msch_frame_tx.sv
// Response frame serialiser: header, node id, length, payload and closing check byte.
`timescale 1ns/1ps
module msch_frame_tx (
    input wire logic i_ref_clk, // 250 MHz clock
    input wire logic i_rst, // synchronous reset
    input wire logic i_start, // one-cycle request to send a frame
    input wire logic [7:0] i_hdr, // header byte
    input wire logic [15:0] i_node, // local node id
    input wire logic [7:0] i_len, // payload length, code included
    output logic [4:0] o_pl_idx, // payload byte wanted next
    input wire logic [7:0] i_pl_byte, // payload byte at o_pl_idx
    input wire logic i_cts_ok, // far end may take bytes
    output logic o_tx_valid, // byte offered
    output logic [7:0] o_tx_data, // byte value
    input wire logic i_tx_ready, // byte taken when high with valid
    output logic o_done // one-cycle pulse after the last byte
);
    import msch_pkg::*;

    logic busy_q;
    logic done_q;
    logic [7:0] pos_q;
    logic [7:0] data_q;
    logic [7:0] xor_q;
    logic [7:0] nxt;
    logic [7:0] nb;
    logic last;
    logic acc;

    assign o_tx_valid = busy_q && i_cts_ok;
    assign acc = o_tx_valid && i_tx_ready;
    assign last = pos_q == 8'(i_len + 8'(IDX_CMD));
    assign nxt = 8'(pos_q + 8'h0001);
    assign o_pl_idx = 5'(nxt - 8'(IDX_CMD));
    // The check byte is the running XOR, so the whole frame folds to zero.
    assign nb = (nxt == 8'(IDX_LQI)) ? LQI_BYTE :
                (nxt == 8'(IDX_NODE_HI)) ? i_node[15:8] :
                (nxt == 8'(IDX_NODE_LO)) ? i_node[7:0] :
                (nxt == 8'(IDX_LEN)) ? i_len :
                (nxt == 8'(i_len + 8'(IDX_CMD))) ? 8'(xor_q ^ data_q) : i_pl_byte;
    assign o_tx_data = data_q;
    assign o_done = done_q;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            pos_q <= 8'h0000;
            data_q <= 8'h0000;
            xor_q <= 8'h0000;
        end else begin
            done_q <= acc && last;
            if (i_start && !busy_q) begin
                busy_q <= 1'b1;
                pos_q <= 8'(IDX_HDR);
                data_q <= i_hdr;
                xor_q <= 8'h0000;
            end else if (acc) begin
                xor_q <= xor_q ^ data_q;
                pos_q <= nxt;
                data_q <= nb;
                if (last) begin
                    busy_q <= 1'b0;
                end
            end
        end
    end

    chk_xor_close: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        acc && last |-> xor_q == o_tx_data) else $error("check byte does not close the frame");
    chk_len_slot: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        acc && pos_q == 8'(IDX_LEN) |-> o_tx_data == i_len) else $error("length byte wrong");
endmodule // msch_frame_tx

// file: rtl/msch_top.sv
// Serial command handler: frame receiver, command execution, scan, tag reports and sleep.
//
// Behaviour
// - Pin-write 0xAD carries pin/level byte pairs, each applied in turn.
// - Pin numbers 3 to 10 only; level 0 drives low, 1 high.
// - Scan 0xBC gathers one-hop neighbour addresses and signal strength, then reports.
// - Scan waits ten seconds for answers and responds inside that window; here the scan fills the window and the answer starts two cycles after it.
// - Scan payload is code then up to ten 2-byte address, 1-byte strength entries.
// - Response: header, byte, node id, length, code or FF, payload, XOR byte.
// - A scan with no neighbours still answers with the bare scan code.
// - Type query 0xC3 returns one byte with the module variant code.
// - Nonzero tag period sends a report every period times 100 ms.
// - Each report holds two 10-bit converter samples in 2-byte fields.
// - Tag mode with idle sleep set sleeps whenever nothing is due.
// - Sleep 0xB1 takes a wake source, only 0 valid; confirm byte 0x00.
// - A frame arriving while asleep wakes the block and reports 0xB2, 0.
// - Parity setting: 0 none, 1 odd, 2 even.
// - Flow setting 1 enables request and clear handshake lines.
// - Loopback setting 1 returns each transparent message to its sender.
// - Frame length is payload plus six; XOR of all bytes is zero.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
module msch_top #(
    parameter int unsigned SCAN_CYCLES = 32'(msch_pkg::SCAN_WAIT_CYC),
    parameter int unsigned TAG_UNIT_CYCLES = 32'(msch_pkg::TAG_UNIT_CYC),
    parameter logic [7:0] MODULE_TYPE = 8'h005A // arbitrary variant code
) (
    input wire logic i_ref_clk, // 250 MHz clock
    input wire logic i_rst, // synchronous reset, active high
    input wire logic [7:0] i_reg_addr, // register byte address
    input wire logic [31:0] i_reg_wdata, // register write data
    input wire logic i_reg_wr, // register write strobe
    input wire logic i_reg_rd, // register read strobe
    output logic [31:0] o_reg_rdata, // read data, cycle after the strobe
    input wire logic i_rx_valid, // received serial byte strobe
    input wire logic [7:0] i_rx_data, // received serial byte
    input wire logic i_rx_parity_err, // parity failed on this byte
    output logic o_tx_valid, // response byte offered
    output logic [7:0] o_tx_data, // response byte
    input wire logic i_tx_ready, // serial port takes the byte
    output logic [1:0] o_serial_parity_select, // parity mode for the port
    output logic o_flow_request_n, // request line, low when bytes may come
    input wire logic i_flow_clear_n, // clear line pin, low when we may send
    output logic [7:0] o_port_level, // pins 3 to 10, bit 0 is pin 3
    output logic o_scan_start, // one-cycle start of a neighbour search
    input wire logic i_nbr_valid, // one neighbour answer
    input wire msch_pkg::msch_nbr_s i_nbr, // neighbour address and strength
    input wire logic i_scan_done, // radio ended the search early
    input wire msch_pkg::msch_adc_s i_adc, // analog_channel_pair samples
    output logic o_tag_report_valid, // tag report waiting for the radio
    output msch_pkg::msch_adc_s o_tag_report, // captured samples
    input wire logic i_tag_report_done, // radio finished sending the report
    input wire logic i_tmsg_valid, // transparent message received
    input wire logic [15:0] i_tmsg_src, // its originating node
    output logic o_loopback_valid, // one-cycle request to echo it back
    output logic [15:0] o_loopback_dst, // node to echo to
    output logic o_sleep // low-power request
);
    import msch_pkg::*;

    typedef enum logic [2:0] {ST_RX, ST_EXEC, ST_PIN, ST_SCAN, ST_SEND, ST_WAIT} msch_state_e;

    msch_state_e st_q;
    msch_cfg_s cfg_q;
    logic [15:0] node_q;
    logic [31:0] rdata_q;
    logic [7:0] rxb_q [RX_MAX];
    logic [7:0] rsp_q [RSP_MAX];
    logic [5:0] rx_cnt_q;
    logic [7:0] rx_xor_q;
    logic [7:0] len_q;
    logic [3:0] seq_q;
    logic [7:0] rsp_len_q;
    logic [7:0] idx_q;
    logic pin_err_q;
    logic [7:0] port_q;
    logic sleep_q;
    logic sleep_pend_q;
    logic scan_start_q;
    logic [31:0] scan_cnt_q;
    logic [3:0] nbr_n_q;
    logic [31:0] unit_cnt_q;
    logic [7:0] unit_n_q;
    logic tag_valid_q;
    msch_adc_s tag_q;
    logic lb_valid_q;
    logic [15:0] lb_dst_q;
    logic cts_m_q;
    logic cts_q;

    function automatic logic [4:0] nbr_slot(input logic [3:0] n);
        nbr_slot = 5'(1 + NBR_BYTES * n);
    endfunction

    // Register decode.
    wire wr_cfg = i_reg_wr && i_reg_addr == REG_CFG;
    wire wr_node = i_reg_wr && i_reg_addr == REG_NODE;
    wire msch_stat_s stat = '{scan_busy: st_q == ST_SCAN, tag_busy: tag_valid_q,
                              sleeping: o_sleep, port_level: port_q};
    wire [31:0] rd_mux = (i_reg_addr == REG_CFG) ? 32'(cfg_q) :
                         (i_reg_addr == REG_NODE) ? 32'(node_q) :
                         (i_reg_addr == REG_STAT) ? 32'(stat) : 32'h0000_0000;

    // Receive path.
    wire par_on = cfg_q.serial_parity_select != PAR_NONE;
    wire rx_here = i_rx_valid && st_q == ST_RX;
    wire rx_bad = rx_here && par_on && i_rx_parity_err;
    wire rx_take = rx_here && !rx_bad;
    wire [7:0] rx_x = rx_xor_q ^ i_rx_data;
    wire hdr_ok = (i_rx_data & HDR_MASK) == REQ_HDR;
    wire len_ok = i_rx_data >= 8'h0001 && i_rx_data <= 8'(RX_MAX - FRAME_OVH);
    wire rx_last = rx_cnt_q > 6'(IDX_LEN) && {2'b00, rx_cnt_q} == 8'(len_q + 8'(IDX_CMD));
    wire frame_end = rx_take && rx_last;
    wire frame_ok = frame_end && rx_x == 8'h0000;

    // Command decode.
    wire [7:0] cmd = rxb_q[IDX_CMD];
    wire [7:0] prm = rxb_q[IDX_PL];
    wire is_sleep = cmd == CMD_SLEEP;
    wire sleep_ok = len_q == 8'h0002 && prm == WAKE_BY_SERIAL;
    wire ex_known = cmd == CMD_TYPE || (is_sleep && sleep_ok);
    wire [7:0] ex_b0 = ex_known ? cmd : CODE_ERR;
    wire [7:0] ex_b1 = !ex_known ? cmd : (cmd == CMD_TYPE) ? MODULE_TYPE : CONFIRM;

    // Pin-write pair walk.
    wire pair_left = 8'(idx_q + 8'h0001) <= 8'(len_q + 8'(IDX_LEN));
    wire [7:0] pin = rxb_q[5'(idx_q)];
    wire [7:0] lvl = rxb_q[5'(idx_q + 8'h0001)];
    wire pair_ok = pin >= PIN_FIRST && pin <= PIN_LAST && lvl <= LVL_HIGH;
    wire [2:0] pin_bit = 3'(pin - PIN_FIRST);

    // Scan window end in its last cycle; the answer starts two cycles after the window.
    wire scan_end = i_scan_done || scan_cnt_q == SCAN_CYCLES - 32'h0000_0001;
    wire nbr_take = i_nbr_valid && nbr_n_q < 4'(NBR_MAX);

    // Tag timer.
    wire tag_on = cfg_q.tag_report_period != 8'h0000;
    wire unit_wrap = unit_cnt_q == TAG_UNIT_CYCLES - 32'h0000_0001;
    wire tag_fire = tag_on && unit_wrap && unit_n_q == 8'(cfg_q.tag_report_period - 8'h0001);
    wire rx_idle = st_q == ST_RX && rx_cnt_q == 6'h00;

    // Transmitter hookup.
    wire tx_done;
    wire [4:0] pl_idx;
    wire cts_ok = !cfg_q.serial_flow_control_select || !cts_q;

    assign o_reg_rdata = rdata_q;
    assign o_serial_parity_select = cfg_q.serial_parity_select;
    assign o_flow_request_n = cfg_q.serial_flow_control_select ? st_q != ST_RX : 1'b0;
    assign o_port_level = port_q;
    assign o_scan_start = scan_start_q;
    assign o_tag_report_valid = tag_valid_q;
    assign o_tag_report = tag_q;
    assign o_loopback_valid = lb_valid_q;
    assign o_loopback_dst = lb_dst_q;
    // Idle sleep drops the moment a report falls due, so the radio can send it.
    assign o_sleep = sleep_q || (tag_on && cfg_q.tag_idle_sleep_enable && !tag_valid_q && rx_idle);

    msch_frame_tx u_tx (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_start(st_q == ST_SEND),
        .i_hdr(RSP_HDR | {4'h0, seq_q}),
        .i_node(node_q),
        .i_len(rsp_len_q),
        .o_pl_idx(pl_idx),
        .i_pl_byte(rsp_q[pl_idx]),
        .i_cts_ok(cts_ok),
        .o_tx_valid(o_tx_valid),
        .o_tx_data(o_tx_data),
        .i_tx_ready(i_tx_ready),
        .o_done(tx_done)
    );

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cfg_q <= '0;
            node_q <= NODE_RST;
            rdata_q <= 32'h0000_0000;
            cts_m_q <= 1'b1;
            cts_q <= 1'b1;
        end else begin
            cts_m_q <= i_flow_clear_n;
            cts_q <= cts_m_q;
            rdata_q <= i_reg_rd ? rd_mux : 32'h0000_0000;
            if (wr_cfg) begin
                cfg_q <= msch_cfg_s'(i_reg_wdata[$bits(msch_cfg_s)-1:0]);
            end
            if (wr_node) begin
                node_q <= i_reg_wdata[15:0];
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (rx_take) begin
            rxb_q[5'(rx_cnt_q)] <= i_rx_data;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            st_q <= ST_RX;
            rx_cnt_q <= 6'h00;
            rx_xor_q <= 8'h0000;
            len_q <= 8'h0000;
            seq_q <= 4'h0;
            rsp_len_q <= 8'h0000;
            idx_q <= 8'h0000;
            pin_err_q <= 1'b0;
            port_q <= 8'h0000;
            sleep_q <= 1'b0;
            sleep_pend_q <= 1'b0;
            scan_start_q <= 1'b0;
            scan_cnt_q <= 32'h0000_0000;
            nbr_n_q <= 4'h0;
        end else begin
            scan_start_q <= 1'b0;
            case (st_q)
                ST_RX: begin
                    if (rx_bad || frame_end || (rx_take && rx_cnt_q == 6'(IDX_LEN) && !len_ok)) begin
                        rx_cnt_q <= 6'h00;
                        rx_xor_q <= 8'h0000;
                    end else if (rx_take && (rx_cnt_q != 6'(IDX_HDR) || hdr_ok)) begin
                        rx_cnt_q <= 6'(rx_cnt_q + 6'h01);
                        rx_xor_q <= rx_x;
                    end
                    if (rx_take && rx_cnt_q == 6'(IDX_HDR)) begin
                        seq_q <= i_rx_data[3:0];
                    end
                    if (rx_take && rx_cnt_q == 6'(IDX_LEN)) begin
                        len_q <= i_rx_data;
                    end
                    if (frame_ok && sleep_q) begin
                        sleep_q <= 1'b0;
                        rsp_q[0] <= CMD_WAKE;
                        rsp_q[1] <= CONFIRM;
                        rsp_len_q <= 8'h0002;
                        st_q <= ST_SEND;
                    end else if (frame_ok) begin
                        st_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (cmd == CMD_PIN_WR) begin
                        idx_q <= 8'(IDX_PL);
                        pin_err_q <= !len_q[0];
                        st_q <= ST_PIN;
                    end else if (cmd == CMD_SCAN) begin
                        scan_start_q <= 1'b1;
                        scan_cnt_q <= 32'h0000_0000;
                        nbr_n_q <= 4'h0;
                        rsp_q[0] <= CMD_SCAN;
                        st_q <= ST_SCAN;
                    end else begin
                        rsp_q[0] <= ex_b0;
                        rsp_q[1] <= ex_b1;
                        rsp_len_q <= 8'h0002;
                        sleep_pend_q <= is_sleep && sleep_ok;
                        st_q <= ST_SEND;
                    end
                end
                ST_PIN: begin
                    if (pair_left) begin
                        if (pair_ok) begin
                            port_q[pin_bit] <= lvl[0];
                        end else begin
                            pin_err_q <= 1'b1;
                        end
                        idx_q <= 8'(idx_q + 8'h0002);
                    end else begin
                        rsp_q[0] <= pin_err_q ? CODE_ERR : CMD_PIN_WR;
                        rsp_q[1] <= pin_err_q ? CMD_PIN_WR : CONFIRM;
                        rsp_len_q <= 8'h0002;
                        st_q <= ST_SEND;
                    end
                end
                ST_SCAN: begin
                    scan_cnt_q <= 32'(scan_cnt_q + 32'h0000_0001);
                    if (scan_end) begin
                        // An entry in the closing cycle is dropped; the list is already fixed.
                        rsp_len_q <= 8'(nbr_slot(nbr_n_q));
                        st_q <= ST_SEND;
                    end else if (nbr_take) begin
                        rsp_q[nbr_slot(nbr_n_q)] <= i_nbr.addr[15:8];
                        rsp_q[5'(nbr_slot(nbr_n_q) + 5'h01)] <= i_nbr.addr[7:0];
                        rsp_q[5'(nbr_slot(nbr_n_q) + 5'h02)] <= i_nbr.rssi;
                        nbr_n_q <= 4'(nbr_n_q + 4'h1);
                    end
                end
                ST_SEND: begin
                    st_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (tx_done) begin
                        sleep_q <= sleep_pend_q;
                        sleep_pend_q <= 1'b0;
                        st_q <= ST_RX;
                    end
                end
                default: begin
                    st_q <= ST_RX;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            unit_cnt_q <= 32'h0000_0000;
            unit_n_q <= 8'h0000;
            tag_valid_q <= 1'b0;
            tag_q <= '0;
            lb_valid_q <= 1'b0;
            lb_dst_q <= 16'h0000;
        end else begin
            if (!tag_on || unit_wrap) begin
                unit_cnt_q <= 32'h0000_0000;
            end else begin
                unit_cnt_q <= 32'(unit_cnt_q + 32'h0000_0001);
            end
            if (!tag_on || tag_fire) begin
                unit_n_q <= 8'h0000;
            end else if (unit_wrap) begin
                unit_n_q <= 8'(unit_n_q + 8'h0001);
            end
            if (tag_fire) begin
                tag_valid_q <= 1'b1;
                tag_q.ch0 <= 16'(i_adc.ch0[ADC_BITS-1:0]);
                tag_q.ch1 <= 16'(i_adc.ch1[ADC_BITS-1:0]);
            end else if (i_tag_report_done) begin
                tag_valid_q <= 1'b0;
            end
            lb_valid_q <= cfg_q.transparent_loopback_enable && i_tmsg_valid;
            if (i_tmsg_valid) begin
                lb_dst_q <= i_tmsg_src;
            end
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    sequence s_frame_in_sleep;
        frame_ok && sleep_q;
    endsequence
    sequence s_wake_report;
        !sleep_q && rsp_q[0] == CMD_WAKE ##1 st_q == ST_WAIT;
    endsequence

    chk_wake_report: assert property (s_frame_in_sleep |=> s_wake_report)
        else $error("wake report missing");
    chk_pin_source: assert property ($changed(port_q) |-> $past(st_q) == ST_PIN && $past(pair_ok))
        else $error("port level changed outside a valid pair");
    chk_pin_range: assert property (st_q == ST_PIN && pair_left && pin > PIN_LAST |=> $stable(port_q))
        else $error("out of range pin applied");
    chk_scan_window: assert property (st_q == ST_SCAN |-> scan_cnt_q < SCAN_CYCLES)
        else $error("scan ran past its window");
    chk_scan_entries: assert property (st_q == ST_SCAN && scan_end |=>
        rsp_len_q == 8'(1 + NBR_BYTES * nbr_n_q) && rsp_q[0] == CMD_SCAN) else $error("scan length wrong");
    chk_sleep_ack: assert property (st_q == ST_EXEC && is_sleep && sleep_ok |=>
        rsp_q[1] == CONFIRM ##1 st_q == ST_WAIT && sleep_pend_q) else $error("sleep confirm wrong");
    chk_tag_report: assert property (tag_fire |=> tag_valid_q && tag_q.ch0[15:ADC_BITS] == '0)
        else $error("tag report not raised");
    chk_idle_sleep: assert property (tag_on && cfg_q.tag_idle_sleep_enable && tag_valid_q
        && !sleep_q |-> !o_sleep) else $error("asleep while report pending");
    chk_flow_off: assert property (!cfg_q.serial_flow_control_select |-> !o_flow_request_n && cts_ok)
        else $error("handshake active while disabled");
    chk_loopback: assert property (i_tmsg_valid && cfg_q.transparent_loopback_enable |=>
        o_loopback_valid && o_loopback_dst == $past(i_tmsg_src)) else $error("loopback missing");
endmodule // msch_top

// file: test/msch_host_model.sv
// Host model: builds request frames and collects response bytes.
`timescale 1ns/1ps
module msch_host_model (
    input wire logic i_ref_clk, // clock
    input wire logic i_tx_valid, // response byte offered
    input wire logic [7:0] i_tx_data, // response byte
    input wire logic i_slow, // take a byte only every other cycle
    output logic o_rx_valid = 1'b0, // request byte strobe
    output logic [7:0] o_rx_data = 8'h00, // request byte
    output logic o_tx_ready = 1'b1 // response byte taken
);
    logic [7:0] rsp[$];
    logic [3:0] seq = 4'h0;
    always @(posedge i_ref_clk) begin
        o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
        if (i_tx_valid && o_tx_ready) rsp.push_back(i_tx_data);
    end
    task automatic send(input logic [7:0] pl[$]);
        logic [7:0] f[$];
        logic [7:0] x;
        seq++;
        f = {8'h80 | {4'h0, seq}, 8'h00, 8'h00, 8'h01, 8'(pl.size())};
        f = {f, pl};
        x = 8'h00;
        foreach (f[i]) x ^= f[i];
        f.push_back(x);
        foreach (f[i]) begin
            @(posedge i_ref_clk);
            o_rx_valid <= 1'b1;
            o_rx_data <= f[i];
        end
        @(posedge i_ref_clk);
        o_rx_valid <= 1'b0;
        o_rx_data <= ~o_rx_data;
    endtask
endmodule // msch_host_model

// file: test/msch_top_tb.sv
// Self-checking bench for the serial command handler.
`timescale 1ns/1ps
module msch_top_tb;
    import msch_pkg::*;
    logic i_ref_clk = 0, i_rst = 1, i_reg_wr = 0, i_reg_rd = 0, i_rx_parity_err = 0, i_flow_clear_n = 0, slow = 0;
    logic i_nbr_valid = 0, i_scan_done = 0, i_tag_report_done = 0, i_tmsg_valid = 0, i_rx_valid, i_tx_ready;
    logic o_tx_valid, o_flow_request_n, o_scan_start, o_tag_report_valid, o_loopback_valid, o_sleep;
    logic [7:0] i_reg_addr = 0, i_rx_data, o_tx_data, o_port_level;
    logic [31:0] i_reg_wdata = 0, o_reg_rdata;
    logic [15:0] i_tmsg_src = 0, o_loopback_dst;
    logic [1:0] o_serial_parity_select;
    msch_nbr_s i_nbr = 24'h00_0AE3;
    msch_adc_s i_adc = '0, o_tag_report;
    int fail_count = 0, total_checks = 0;
    msch_top #(.SCAN_CYCLES(200), .TAG_UNIT_CYCLES(10)) i_dut (.i_ref_clk, .i_rst, .i_reg_addr, .i_reg_wdata,
        .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_rx_valid, .i_rx_data, .i_rx_parity_err, .o_tx_valid, .o_tx_data,
        .i_tx_ready, .o_serial_parity_select, .o_flow_request_n, .i_flow_clear_n, .o_port_level, .o_scan_start,
        .i_nbr_valid, .i_nbr, .i_scan_done, .i_adc, .o_tag_report_valid, .o_tag_report, .i_tag_report_done,
        .i_tmsg_valid, .i_tmsg_src, .o_loopback_valid, .o_loopback_dst, .o_sleep);
    msch_host_model host (.i_ref_clk, .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data), .i_slow(slow),
        .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data), .o_tx_ready(i_tx_ready));
    always #2 i_ref_clk = ~i_ref_clk;
    // Radio stand-in: odd rows, and only they, hear one neighbour and then end the scan early.
    always @(posedge i_ref_clk) begin
        i_nbr_valid <= o_scan_start && slow;
        i_scan_done <= i_nbr_valid;
    end
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic reg_op(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_reg_wr <= wr;
        i_reg_rd <= ~wr;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_ref_clk);
        i_reg_wr <= 1'b0;
        i_reg_rd <= 1'b0;
        #1;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Rows: request payload, right aligned, and expected response payload; row 6 is sent while asleep.
    // Row 4 scans with no neighbour, row 7 hears one.
    logic [39:0] rq[8] = '{40'hC3, 40'hAD_0301_0A01, 40'hAD_0201_0B01, 40'hB101, 40'hBC, 40'hB100, 40'hC3, 40'hBC};
    int rn[8] = '{1, 5, 5, 2, 1, 2, 1, 1};
    logic [31:0] ex[8] = '{32'hC35A, 32'hAD00, 32'hFFAD, 32'hFFB1, 32'hBC, 32'hB100, 32'hB200, 32'hBC00_0AE3};
    int en[8] = '{2, 2, 2, 2, 1, 2, 2, 4};
    initial begin
        logic [7:0] q[$];
        logic [7:0] e[$];
        logic [7:0] x;
        repeat (16) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        #1 check("reset", 32'h0000_0000, {o_flow_request_n, o_sleep, o_port_level});
        $display("reset test done");
        for (int r = 0; r < 8; r++) begin
            q = {};
            for (int j = 0; j < rn[r]; j++) q.push_back(rq[r][8*(rn[r]-j)-1 -: 8]);
            host.rsp = {};
            slow <= r[0];
            host.send(q);
            e = {8'hC0 | 8'(r + 1), 8'h00, 8'h00, 8'h00, 8'(en[r])};
            for (int j = 0; j < en[r]; j++) e.push_back(ex[r][8*(en[r]-j)-1 -: 8]);
            x = 8'h00;
            foreach (e[j]) x ^= e[j];
            e.push_back(x);
            for (int k = 0; k < 2000 && host.rsp.size() < e.size(); k++) @(posedge i_ref_clk);
            repeat (4) @(posedge i_ref_clk);
            check("length", e.size(), host.rsp.size());
            foreach (e[j]) check("byte", e[j], host.rsp[j]);
            $display("row %0d done", r);
        end
        check("pins", 8'h81, o_port_level);
        reg_op(1'b1, REG_CFG, 32'h0000_1400);
        check("parity", PAR_EVEN, o_serial_parity_select);
        q = {8'hC3};
        host.rsp = {};
        i_rx_parity_err <= 1'b1;
        host.send(q);
        i_rx_parity_err <= 1'b0;
        repeat (40) @(posedge i_ref_clk);
        check("parity abort", 0, host.rsp.size());
        reg_op(1'b0, REG_STAT, 32'h0000_0000);
        check("status", 32'h0000_0081, o_reg_rdata);
        reg_op(1'b0, 8'h3C, 32'h0000_0000);
        check("unmapped", 32'h0000_0000, o_reg_rdata);
        i_tmsg_valid <= 1'b1;
        i_tmsg_src <= 16'h1234;
        @(posedge i_ref_clk);
        i_tmsg_valid <= 1'b0;
        #1 check("loopback", 32'h0001_1234, {o_loopback_valid, o_loopback_dst});
        $display("register and loopback tests done");
        i_adc <= 32'hFFFF_0155;
        reg_op(1'b1, REG_CFG, 32'h0000_1502);
        check("idle sleep", 1, o_sleep);
        repeat (19) @(posedge i_ref_clk);
        #1 check("tag early", 0, o_tag_report_valid);
        @(posedge i_ref_clk);
        #1 check("tag due", 2'b10, {o_tag_report_valid, o_sleep});
        check("tag samples", 32'h03FF_0155, o_tag_report);
        i_tag_report_done <= 1'b1;
        @(posedge i_ref_clk);
        i_tag_report_done <= 1'b0;
        #1 check("tag sent", 1, o_sleep);
        $display("tag test done");
        summarize();
    end
    initial begin
        #100000;
        fail_count++;
        summarize();
    end
endmodule // msch_top_tb
